// File: rtl/gauge_mode_command_regs.sv
/*
 * mode and command register bank of the fuel gauge: pin control, trigger
 * commands, powerup flag, rate input, time-to-empty, temperature, voltage.
 * assumes the serial engine presents decoded byte accesses on clk, and
 * capacity logic elsewhere acts on the command pulses.
 */
`timescale 1ns/1ps
module gauge_mode_command_regs #(
    parameter int unsigned REFRESH_CYCLES = gauge_pkg::REFRESH_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    input  wire logic [7:0]  pack_setup_rom,
    input  wire logic        gpio_in,
    output logic             gpio_out,
    output logic             gpio_oe,
    input  wire logic [15:0] temp_sample,
    input  wire logic [15:0] volt_sample,
    input  wire logic [15:0] predicted_usable_level,
    input  wire logic        full_charge_evt,
    output gauge_pkg::cmd_s  cmd
);
    gauge_pkg::regs_state_s r_reg;
    gauge_pkg::regs_state_s r_next;
    logic                   tick;
    logic [15:0]            minutes;
    logic                   exec;

    assign exec = (r_reg.ctrl == gauge_pkg::TRIGGER_CODE);

    // divider needs 23 cycles between restarts to finish
    if (REFRESH_CYCLES < 32'h0000_0018) begin : g_bad_period
        $error("gauge_mode_command_regs: REFRESH_CYCLES below 24");
    end

    refresh_timer #(
        .CYCLES (REFRESH_CYCLES)
    ) u_timer (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (tick)
    );

    // R17 prediction engine
    minutes_divider u_div (
        .clk     (clk),
        .arst_n  (arst_n),
        .start   (r_reg.calc_start),
        .usable  (predicted_usable_level),
        .rate    (r_reg.rate),
        .minutes (minutes)
    );

    always_comb begin
        r_next = r_reg;
        r_next.cmd = '0;
        r_next.rvalid = 1'b0;
        r_next.calc_start = 1'b0;
        r_next.pin_meta = gpio_in;
        r_next.pin_sync = r_reg.pin_meta;
        // R2 first cycle load
        if (!r_reg.init_done) begin
            r_next.init_done = 1'b1;
            r_next.mode[gauge_pkg::DIR_BIT] =
                pack_setup_rom[gauge_pkg::ROM_DIR_BIT];
        end
        // R8 full charge clears
        if (full_charge_evt) begin
            r_next.mode[gauge_pkg::PWR_BIT] = 1'b0;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                gauge_pkg::CTRL_OFS: begin
                    // R21 only trigger code taken
                    if (reg_wdata == gauge_pkg::TRIGGER_CODE) begin
                        r_next.ctrl = reg_wdata;
                    end
                end
                gauge_pkg::MODE_OFS: begin
                    // R9 powerup bit stored only
                    r_next.mode = reg_wdata;
                end
                gauge_pkg::RATE_LO_OFS: begin
                    // R16 raw rate counts
                    r_next.rate[7:0] = reg_wdata;
                    r_next.calc_start = 1'b1;
                end
                gauge_pkg::RATE_HI_OFS: begin
                    r_next.rate[15:8] = reg_wdata;
                    r_next.calc_start = 1'b1;
                end
                default: begin
                    // R18 read-only and unmapped ignored
                end
            endcase
        end
        if (exec) begin
            // R13 highest priority only
            if (r_reg.mode[gauge_pkg::LOAD_BIT]) begin
                // R5 rate into remaining
                r_next.cmd.load_remaining = 1'b1;
            end else if (r_reg.mode[gauge_pkg::DONE_BIT]) begin
                // R6 force full
                r_next.cmd.force_full = 1'b1;
            end else if (r_reg.mode[gauge_pkg::SOFT_BIT]) begin
                // R7 partial reinit
                r_next.cmd.soft_reinit = 1'b1;
                r_next.rate = gauge_pkg::RATE_RST;
                r_next.mode[gauge_pkg::DIR_BIT] =
                    pack_setup_rom[gauge_pkg::ROM_DIR_BIT];
            end else if (r_reg.mode[gauge_pkg::TOTAL_BIT]) begin
                // R10 full reinit
                r_next.cmd.total_reinit = 1'b1;
                r_next.rate = gauge_pkg::RATE_RST;
                r_next.mode[gauge_pkg::DIR_BIT] =
                    pack_setup_rom[gauge_pkg::ROM_DIR_BIT];
            end else if (r_reg.mode[gauge_pkg::SHIP_BIT]) begin
                // R11 ship mode request
                r_next.cmd.ship_enter = 1'b1;
            end
            // R14 clear commands and trigger
            r_next.mode = r_next.mode & ~gauge_pkg::CMD_MASK;
            r_next.ctrl = gauge_pkg::CTRL_RST;
        end
        r_next.cmd.load_value = r_reg.rate;
        if (tick) begin
            // R19 temperature refresh
            r_next.temp = temp_sample;
            // R20 voltage clamp
            if (volt_sample > gauge_pkg::VOLT_MAX_MV) begin
                r_next.volt = gauge_pkg::VOLT_MAX_MV;
            end else begin
                r_next.volt = volt_sample;
            end
            r_next.calc_start = 1'b1;
        end
        if (reg_rd) begin
            r_next.rvalid = 1'b1;
            unique case (reg_addr)
                gauge_pkg::CTRL_OFS:    r_next.rdata = r_reg.ctrl;
                gauge_pkg::MODE_OFS: begin
                    r_next.rdata = r_reg.mode;
                    // R4 pin level from the two-flop synchroniser
                    if (r_reg.mode[gauge_pkg::DIR_BIT]) begin
                        r_next.rdata[gauge_pkg::LEVEL_BIT] = r_reg.pin_sync;
                    end
                end
                gauge_pkg::RATE_LO_OFS: r_next.rdata = r_reg.rate[7:0];
                gauge_pkg::RATE_HI_OFS: r_next.rdata = r_reg.rate[15:8];
                gauge_pkg::TTE_LO_OFS:  r_next.rdata = minutes[7:0];
                gauge_pkg::TTE_HI_OFS:  r_next.rdata = minutes[15:8];
                gauge_pkg::TEMP_LO_OFS: r_next.rdata = r_reg.temp[7:0];
                gauge_pkg::TEMP_HI_OFS: r_next.rdata = r_reg.temp[15:8];
                gauge_pkg::VOLT_LO_OFS: r_next.rdata = r_reg.volt[7:0];
                gauge_pkg::VOLT_HI_OFS: r_next.rdata = r_reg.volt[15:8];
                default:                r_next.rdata = 8'h00;
            endcase
        end
    end

    // R12 reset clears commands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
            r_reg.mode <= gauge_pkg::MODE_RST;
            r_reg.ctrl <= gauge_pkg::CTRL_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // R1 R3 open-drain drive
    assign gpio_oe = ~r_reg.mode[gauge_pkg::DIR_BIT] &
                     ~r_reg.mode[gauge_pkg::LEVEL_BIT];
    assign gpio_out = 1'b0;
    assign reg_rdata = r_reg.rdata;
    assign reg_rvalid = r_reg.rvalid;
    assign cmd = r_reg.cmd;

    a_dir_input_release: assert property ( // R1
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == gauge_pkg::MODE_OFS && reg_wdata[7] &&
         !exec) |=> !gpio_oe)
        else $error("pin driven while set as input");

    a_init_dir_load: assert property ( // R2
        @(posedge clk) disable iff (!arst_n)
        $rose(r_reg.init_done) |->
        r_reg.mode[7] == $past(pack_setup_rom[7]))
        else $error("direction not loaded from setup rom");

    a_level_pull_low: assert property ( // R3
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == gauge_pkg::MODE_OFS &&
         reg_wdata[7:6] == 2'b00 && r_reg.init_done && !exec)
        |=> gpio_oe)
        else $error("output low not driven");

    a_pin_level_read: assert property ( // R4
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == gauge_pkg::MODE_OFS && r_reg.mode[7])
        |=> reg_rvalid && reg_rdata[6] == $past(r_reg.pin_sync))
        else $error("input level not returned");

    a_load_rate_value: assert property ( // R5
        @(posedge clk) disable iff (!arst_n)
        cmd.load_remaining |-> $past(exec) && $past(r_reg.mode[5]) &&
        cmd.load_value == $past(r_reg.rate))
        else $error("load pulse or value wrong");

    a_priority_pick: assert property ( // R13
        @(posedge clk) disable iff (!arst_n)
        (exec && r_reg.mode[5]) |=> cmd.load_remaining &&
        !cmd.force_full && !cmd.soft_reinit && !cmd.total_reinit &&
        !cmd.ship_enter)
        else $error("highest command not chosen alone");

    a_trigger_cleanup: assert property ( // R14
        @(posedge clk) disable iff (!arst_n)
        exec |=> r_reg.ctrl == 8'h00 &&
        (r_reg.mode & gauge_pkg::CMD_MASK) == 8'h00)
        else $error("commands or trigger not cleared");

    a_bad_trigger: assert property ( // R21
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == gauge_pkg::CTRL_OFS &&
         reg_wdata != gauge_pkg::TRIGGER_CODE && r_reg.ctrl == 8'h00)
        |=> r_reg.ctrl == 8'h00 ##1 !cmd.ship_enter && !cmd.force_full)
        else $error("non-trigger write acted");

    a_powerup_clear: assert property ( // R8
        @(posedge clk) disable iff (!arst_n)
        (full_charge_evt && !(reg_wr && reg_addr == gauge_pkg::MODE_OFS))
        |=> !r_reg.mode[2])
        else $error("powerup flag not cleared on full");

    a_volt_ceiling: assert property ( // R20
        @(posedge clk) disable iff (!arst_n)
        r_reg.volt <= 16'h1388)
        else $error("voltage above ceiling");

    a_temp_read_only: assert property ( // R18
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == gauge_pkg::TEMP_LO_OFS && !tick)
        |=> $stable(r_reg.temp))
        else $error("temperature changed by host write");
endmodule

// File: rtl/gauge_pkg.sv
/*
 * constants, field layouts and state types of the gauge mode/command bank.
 * assumes a byte-wide register port fed by the single-wire serial engine.
 */
// Function
// R1 - dir bit 1 input, 0 open-drain output
// R2 - dir bit loaded from setup rom bit 7
// R3 - level 1 releases driver, 0 pulls; por 1
// R4 - input mode reads return sampled pin level
// R5 - load command copies rate into remaining coulombs
// R6 - done command copies remaining into full level
// R7 - soft reinit keeps capacity and untrusted flag
// R8 - powerup flag set at por, cleared on full
// R9 - host writing powerup flag changes nothing else
// R10 - total reinit reinitialises all ram registers
// R11 - ship command enters ship low-power mode
// R12 - command bits cleared on every reset
// R13 - trigger runs only highest priority command
// R14 - after command, clear commands and trigger
// R15 - host writes mode first, then trigger
// R16 - rate is 3 uV counts, always discharge
// R17 - minutes left is 60 times usable over rate
// R18 - result, temperature, voltage are read-only
// R19 - temperature 16-bit quarter kelvin, 2 s refresh
// R20 - voltage in mV, 2 s refresh, max 5000
// R21 - non-trigger control writes are ignored
package gauge_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam logic [6:0] CTRL_OFS = 7'h00;
    localparam logic [6:0] MODE_OFS = 7'h01;
    localparam logic [6:0] RATE_LO_OFS = 7'h02;
    localparam logic [6:0] RATE_HI_OFS = 7'h03;
    localparam logic [6:0] TTE_LO_OFS = 7'h04;
    localparam logic [6:0] TTE_HI_OFS = 7'h05;
    localparam logic [6:0] TEMP_LO_OFS = 7'h06;
    localparam logic [6:0] TEMP_HI_OFS = 7'h07;
    localparam logic [6:0] VOLT_LO_OFS = 7'h08;
    localparam logic [6:0] VOLT_HI_OFS = 7'h09;
    localparam int unsigned DIR_BIT = 7;
    localparam int unsigned LEVEL_BIT = 6;
    localparam int unsigned LOAD_BIT = 5;
    localparam int unsigned DONE_BIT = 4;
    localparam int unsigned SOFT_BIT = 3;
    localparam int unsigned PWR_BIT = 2;
    localparam int unsigned TOTAL_BIT = 1;
    localparam int unsigned SHIP_BIT = 0;
    localparam int unsigned ROM_DIR_BIT = 7;
    localparam logic [7:0] CMD_MASK = 8'h3b;
    localparam logic [7:0] MODE_RST = 8'h44;
    localparam logic [7:0] TRIGGER_CODE = 8'ha9;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] RATE_RST = 16'h0000;
    localparam logic [15:0] VOLT_MAX_MV = 16'h1388;
    localparam logic [21:0] MIN_PER_HOUR = 22'h00003c;
    localparam logic [4:0] NUM_STEPS = 5'h16;
    localparam logic [15:0] TTE_SAT = 16'hffff;
    localparam int unsigned REFRESH_MS = 2000;
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned REFRESH_CYCLES = REFRESH_MS * CLK_KHZ;

    typedef struct packed {
        logic        load_remaining;
        logic        force_full;
        logic        soft_reinit;
        logic        total_reinit;
        logic        ship_enter;
        logic [15:0] load_value;
    } cmd_s;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  ctrl;
        logic [15:0] rate;
        logic [15:0] temp;
        logic [15:0] volt;
        logic        pin_meta;
        logic        pin_sync;
        logic        init_done;
        logic        calc_start;
        cmd_s        cmd;
        logic [7:0]  rdata;
        logic        rvalid;
    } regs_state_s;

    typedef enum logic [0:0] {
        DIV_IDLE = 1'b0,
        DIV_RUN  = 1'b1
    } div_state_e;

    typedef struct packed {
        div_state_e  st;
        logic [21:0] num;
        logic [22:0] rem;
        logic [21:0] quo;
        logic [15:0] den;
        logic [4:0]  cnt;
        logic [15:0] result;
    } div_state_s;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } tmr_state_s;
endpackage

// File: rtl/minutes_divider.sv
/*
 * sequential divider: result = 60 * usable / rate, saturating at all ones.
 * operands are latched at start; a new start during the 22 cycles of a run restarts it.
 */
`timescale 1ns/1ps
module minutes_divider (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        start,
    input  wire logic [15:0] usable,
    input  wire logic [15:0] rate,
    output logic [15:0]      minutes
);
    gauge_pkg::div_state_s r_reg;
    gauge_pkg::div_state_s r_next;

    always_comb begin
        logic [22:0] sh;
        sh = {r_reg.rem[21:0], r_reg.num[21]};
        r_next = r_reg;
        if (start) begin
            // R17 scaled dividend
            r_next.st = gauge_pkg::DIV_RUN;
            r_next.num = 22'({6'h00, usable} * gauge_pkg::MIN_PER_HOUR);
            r_next.rem = '0;
            r_next.quo = '0;
            r_next.den = rate;
            r_next.cnt = gauge_pkg::NUM_STEPS;
        end else begin
            unique case (r_reg.st)
                gauge_pkg::DIV_IDLE: begin
                end
                gauge_pkg::DIV_RUN: begin
                    r_next.num = {r_reg.num[20:0], 1'b0};
                    if (sh >= {7'h00, r_reg.den}) begin
                        r_next.rem = sh - {7'h00, r_reg.den};
                        r_next.quo = {r_reg.quo[20:0], 1'b1};
                    end else begin
                        r_next.rem = sh;
                        r_next.quo = {r_reg.quo[20:0], 1'b0};
                    end
                    r_next.cnt = r_reg.cnt - 5'h01;
                    if (r_reg.cnt == 5'h01) begin
                        r_next.st = gauge_pkg::DIV_IDLE;
                        // R16 zero or overflow saturates
                        if (r_reg.den == 16'h0000 ||
                            r_next.quo[21:16] != 6'h00) begin
                            r_next.result = gauge_pkg::TTE_SAT;
                        end else begin
                            r_next.result = r_next.quo[15:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign minutes = r_reg.result;
endmodule

// File: rtl/refresh_timer.sv
/*
 * free-running refresh tick, one pulse per period.
 * assumes a single clock; first tick in the cycle after reset release.
 */
`timescale 1ns/1ps
module refresh_timer #(
    parameter int unsigned CYCLES = gauge_pkg::REFRESH_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      tick
);
    gauge_pkg::tmr_state_s r_reg;
    gauge_pkg::tmr_state_s r_next;

    // a period below 2 cannot count down
    if (CYCLES < 2) begin : g_bad_cycles
        $error("refresh_timer: CYCLES must be at least 2");
    end

    always_comb begin
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (r_reg.cnt == 32'h0000_0000) begin
            r_next.cnt = 32'(CYCLES - 1);
            r_next.tick = 1'b1;
        end else begin
            r_next.cnt = r_reg.cnt - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick = r_reg.tick;
endmodule

// File: testbench/gauge_mode_command_regs_tb_top.sv
/*
 * self-checking bench of the mode/command bank: the host model drives the
 * port, monitors compare read answers and command pulses with queued notes.
 * assumes a short refresh period set through REFRESH_CYCLES.
 */
`timescale 1ns/1ps
module gauge_mode_command_regs_tb_top;
    localparam int unsigned REF = 50;
    logic            clk;
    logic            arst_n;
    logic [6:0]      reg_addr;
    logic [7:0]      reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [7:0]      reg_rdata;
    logic            reg_rvalid;
    logic [7:0]      rom;
    logic            gpio_in;
    logic            gpio_out;
    logic            gpio_oe;
    logic [15:0]     temp;
    logic [15:0]     volt;
    logic [15:0]     usable;
    logic            full;
    gauge_pkg::cmd_s cmd;
    logic [4:0]      seen_cmd;
    logic [4:0]      cmd_q[$];
    logic [15:0]     val_q[$];
    logic [7:0]      d;
    logic [7:0]      m;
    logic [15:0]     r;
    logic [15:0]     t;
    logic [15:0]     exp_b;
    logic [15:0]     exp_c;
    int unsigned     num_errors;
    int unsigned     checked;
    int unsigned     pos[5] = '{gauge_pkg::LOAD_BIT, gauge_pkg::DONE_BIT,
        gauge_pkg::SOFT_BIT, gauge_pkg::TOTAL_BIT, gauge_pkg::SHIP_BIT};

    gauge_mode_command_regs #(.REFRESH_CYCLES(REF))
        gauge_mode_command_regs_inst (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pack_setup_rom(rom), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .temp_sample(temp), .volt_sample(volt),
        .predicted_usable_level(usable), .full_charge_evt(full),
        .cmd(cmd));

    host_model host_model_inst (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    assign seen_cmd = {cmd.load_remaining, cmd.force_full, cmd.soft_reinit,
                       cmd.total_reinit, cmd.ship_enter};

    always #5 clk = ~clk;

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [15:0] tte(input logic [15:0] u,
                                        input logic [15:0] q);
        logic [31:0] x;
        if (q == 16'h0000) return 16'hffff;
        x = (32'h0000003c * u) / q;
        return (x > 32'h0000ffff) ? 16'hffff : x[15:0];
    endfunction

    task automatic trig(input logic [7:0] mv, input logic [4:0] e);
        if (e != 5'h00) cmd_q.push_back(e);
        host_model_inst.command(mv);
    endtask

    always @(posedge clk) begin
        if (reg_rvalid === 1'b1) begin
            if (host_model_inst.exp_q.size() == 0) begin
                check("read answer", 16'h0001, 16'h0000);
            end else begin
                exp_b = 16'(host_model_inst.exp_q.pop_front());
                check("read data", 16'(reg_rdata), exp_b);
            end
        end
        if ((|seen_cmd) === 1'b1) begin
            if (cmd_q.size() == 0) begin
                check("command pulse", {11'h000, seen_cmd}, 16'h0000);
            end else begin
                if (cmd_q[0][4]) begin
                    exp_b = val_q.pop_front();
                    check("load value", cmd.load_value, exp_b);
                end
                exp_c = 16'(cmd_q.pop_front());
                check("command pulse", 16'(seen_cmd), exp_c);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        check("watchdog", 16'h0001, 16'h0000);
        results();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        rom = 8'h80;
        gpio_in = 1'b0;
        temp = 16'h0000;
        volt = 16'h0000;
        usable = 16'h0000;
        full = 1'b0;
        r = $urandom(8);
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        // direction from rom, pin read back
        host_model_inst.rd(gauge_pkg::MODE_OFS, 8'h84);
        check("pin drive", gpio_oe, 1'b0);
        @(posedge clk) gpio_in <= 1'b1;
        repeat (5) @(posedge clk);
        host_model_inst.rd(gauge_pkg::MODE_OFS, 8'hc4);
        host_model_inst.rd(gauge_pkg::CTRL_OFS, 8'h00);
        host_model_inst.rd(7'h0a, 8'h00);
        host_model_inst.wr(gauge_pkg::MODE_OFS, 8'hc0);
        host_model_inst.rd(gauge_pkg::MODE_OFS, 8'hc0);
        host_model_inst.wr(gauge_pkg::MODE_OFS, 8'hc4);
        host_model_inst.rd(gauge_pkg::MODE_OFS, 8'hc4);
        @(posedge clk) full <= 1'b1;
        @(posedge clk) full <= 1'b0;
        host_model_inst.rd(gauge_pkg::MODE_OFS, 8'hc0);
        host_model_inst.wr(gauge_pkg::MODE_OFS, 8'he4);
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            if (d == gauge_pkg::TRIGGER_CODE) d = 8'h5a;
            host_model_inst.wr(gauge_pkg::CTRL_OFS, d);
            host_model_inst.rd(gauge_pkg::CTRL_OFS, 8'h00);
        end
        r = $urandom;
        host_model_inst.write_rate(r);
        host_model_inst.rd(gauge_pkg::RATE_LO_OFS, r[7:0]);
        host_model_inst.rd(gauge_pkg::RATE_HI_OFS, r[15:8]);
        val_q.push_back(r);
        for (int i = 0; i < 5; i++) begin
            m = 8'hc4;
            for (int j = i; j < 5; j++) m[pos[j]] = 1'b1;
            trig(m, 5'h10 >> i);
            repeat (3) @(posedge clk);
            host_model_inst.rd(gauge_pkg::MODE_OFS, 8'hc4);
            host_model_inst.rd(gauge_pkg::CTRL_OFS, 8'h00);
        end
        trig(8'hc4, 5'h00);
        host_model_inst.rd(gauge_pkg::CTRL_OFS, 8'h00);
        temp <= 16'($urandom);
        volt <= 16'h2000 | 16'($urandom);
        usable <= 16'($urandom);
        r = (16'($urandom) & 16'h0fff) + 16'h0001;
        host_model_inst.write_rate(r);
        repeat (2 * REF + 40) @(posedge clk);
        for (int a = 4; a < 10; a++) host_model_inst.wr(7'(a), 8'($urandom));
        t = tte(usable, r);
        host_model_inst.rd(gauge_pkg::TTE_LO_OFS, t[7:0]);
        host_model_inst.rd(gauge_pkg::TTE_HI_OFS, t[15:8]);
        host_model_inst.rd(gauge_pkg::TEMP_LO_OFS, temp[7:0]);
        host_model_inst.rd(gauge_pkg::TEMP_HI_OFS, temp[15:8]);
        host_model_inst.rd(gauge_pkg::VOLT_LO_OFS, 8'h88);
        host_model_inst.rd(gauge_pkg::VOLT_HI_OFS, 8'h13);
        // values under the ceiling pass unchanged
        volt <= 16'($urandom) & 16'h0fff;
        repeat (REF + 30) @(posedge clk);
        host_model_inst.rd(gauge_pkg::VOLT_LO_OFS, volt[7:0]);
        host_model_inst.rd(gauge_pkg::VOLT_HI_OFS, volt[15:8]);
        host_model_inst.wr(gauge_pkg::MODE_OFS, 8'hff);
        @(posedge clk) arst_n <= 1'b0;
        rom <= 8'h00;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        host_model_inst.rd(gauge_pkg::MODE_OFS, 8'h44);
        check("pin drive", gpio_oe, 1'b0);
        host_model_inst.wr(gauge_pkg::MODE_OFS, 8'h04);
        repeat (2) @(posedge clk);
        #1 check("pin drive", gpio_oe, 1'b1);
        check("pin value", gpio_out, 1'b0);
        host_model_inst.wr(gauge_pkg::MODE_OFS, 8'h44);
        repeat (2) @(posedge clk);
        #1 check("pin drive", gpio_oe, 1'b0);
        repeat (5) @(posedge clk);
        check("pending commands", 16'(cmd_q.size()), 16'h0000);
        results();
    end
endmodule

// File: testbench/host_model.sv
/*
 * host processor model on the byte register port: write, read and
 * two-step command tasks; each read notes its expected byte in exp_q.
 * assumes the bench pops exp_q on every read answer.
 */
`timescale 1ns/1ps
module host_model (
    input  wire logic  clk,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd
);
    logic [7:0] exp_q[$];

    initial begin
        reg_addr = 7'h7f;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one access; released address and data lines show the inverse of their last value
    task automatic acc(input logic [6:0] a, input logic [7:0] d,
                       input logic w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        acc(a, d, 1'b1);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(a, ~e, 1'b0);
    endtask

    task automatic write_rate(input logic [15:0] counts);
        wr(gauge_pkg::RATE_LO_OFS, counts[7:0]);
        wr(gauge_pkg::RATE_HI_OFS, counts[15:8]);
    endtask

    task automatic command(input logic [7:0] m);
        wr(gauge_pkg::MODE_OFS, m);
        wr(gauge_pkg::CTRL_OFS, gauge_pkg::TRIGGER_CODE);
    endtask
endmodule
